// file: core/rf_spi_pkg.sv
// Shared constants for both ends of the four-wire serial host port.
// Assumes a single 200 MHz system clock on each end.
package rf_spi_pkg;
  localparam int unsigned CLK_PERIOD_NS = 5;            // System clock period
  localparam int unsigned ADDR_W        = 7;            // Register address width
  localparam int unsigned BYTE_W        = 8;            // Data byte width
  localparam int unsigned FIFO_DEPTH    = 32;           // Receive FIFO bytes
  localparam int unsigned PTR_W         = 5;            // FIFO pointer width
  localparam int unsigned LVL_W         = 6;            // FIFO level width
  localparam int unsigned BCNT_W        = 5;            // Bit counter width
  localparam int unsigned TMR_W         = 10;           // Host timer width

  // Bit positions and lengths of register and FIFO frames
  localparam logic [BCNT_W-1:0] ADDR_LAST_BIT = 5'h07;  // Last address bit index
  localparam logic [BCNT_W-1:0] REG_LAST_BIT  = 5'h0F;  // Last data bit index
  localparam logic [BCNT_W-1:0] FIFO_LAST_BIT = 5'h07;  // Last FIFO data bit
  localparam logic [BCNT_W-1:0] REG_BITS      = 5'h10;  // Register frame length
  localparam logic [BCNT_W-1:0] FIFO_BITS     = 5'h08;  // FIFO frame length

  // Reset values and full level
  localparam logic [PTR_W-1:0]  PTR_RST  = 5'h00;
  localparam logic [LVL_W-1:0]  LVL_RST  = 6'h00;
  localparam logic [LVL_W-1:0]  LVL_FULL = 6'h20;       // Level when all 32 bytes held
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;

  // Timing figures, in their own units
  localparam int unsigned FIFO_HOLD_NS = 2000;          // Select low after last fall
  localparam int unsigned FIFO_GAP_NS  = 4000;          // Select high between bytes

  // Least times round up to whole cycles
  function automatic int unsigned ns_to_cyc_up(input int unsigned ns);
    ns_to_cyc_up = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction : ns_to_cyc_up

  // Cycle counts, loaded into the host timer as count minus one
  localparam int unsigned SCL_HALF_CYC  = 10;           // Half serial clock period
  localparam int unsigned FIFO_HOLD_CYC = ns_to_cyc_up(FIFO_HOLD_NS);
  localparam int unsigned FIFO_GAP_CYC  = ns_to_cyc_up(FIFO_GAP_NS);
  localparam logic [TMR_W-1:0] T_HALF = TMR_W'(SCL_HALF_CYC - 1);
  localparam logic [TMR_W-1:0] T_FULL = TMR_W'(2 * SCL_HALF_CYC - 1);
  localparam logic [TMR_W-1:0] T_HOLD = TMR_W'(FIFO_HOLD_CYC - 1);
  localparam logic [TMR_W-1:0] T_GAP  = TMR_W'(FIFO_GAP_CYC - 1);
endpackage : rf_spi_pkg

// file: core/spi_link_if.sv
// Serial link between host and device: two selects, clock, one shared data pin.
// Assumes the data pin is pulled high when neither end drives it.
`timescale 1ns/1ps
interface spi_link_if;
  logic reg_select_n;   // Register access select, active low
  logic fifo_select_n;  // FIFO read select, active low
  logic scl;            // Serial clock, made by the host
  logic sda_host_o;     // Host data out
  logic sda_host_oe;    // Host drives data pin
  logic sda_dev_o;      // Device data out
  logic sda_dev_oe;     // Device drives data pin
  logic sda;            // Resolved pin level

  // Pull-up when released; host wins if both drive (illegal overlap)
  assign sda = sda_host_oe ? sda_host_o : (sda_dev_oe ? sda_dev_o : 1'b1);

  modport host   (output reg_select_n, fifo_select_n, scl, sda_host_o, sda_host_oe,
                  input sda);
  modport device (input reg_select_n, fifo_select_n, scl, sda,
                  output sda_dev_o, sda_dev_oe);
endinterface : spi_link_if

// file: core/rf_spi_device.sv
// Device end of the serial host port: register frames and receive FIFO reads.
// Assumes link pins are synchronous to CLK and the host keeps its timing.
// Notes on behaviour
// RQ1: Low register select opens a register frame.
// RQ2: Low FIFO select opens a FIFO read.
// RQ3: Host never lowers both selects together.
// RQ4: Drive on falling edge, sample on rising.
// RQ5: Each end releases data pin for other.
// RQ6: Addresses and data travel MSB first.
// RQ7: Register frame: direction bit, then 7-bit address.
// RQ8: Register select low half period before start.
// RQ9: Register select low half period after end.
// RQ10: Read pointer advances per byte, no address.
// RQ11: FIFO select low one period before clocking.
// RQ12: FIFO select stays low 2 us after.
// RQ13: FIFO select high 4 us; status refreshed.
// RQ14: Sleep serves registers, refuses FIFO reads.
// RQ15: Eight data bits follow the address.
`timescale 1ns/1ps
module rf_spi_device
  import rf_spi_pkg::*;
(
  input  wire logic              CLK,            // System clock
  input  wire logic              ARST_N,         // Async reset, active low
  spi_link_if.device             LINK,           // Serial link
  input  wire logic              SLEEP,          // Device in low-power sleep state
  output logic [ADDR_W-1:0]      REG_ADDR,       // Register address of frame
  output logic                   REG_RD_STB,     // Read address known, pulse
  input  wire logic [BYTE_W-1:0] REG_RD_DATA,    // Register contents at REG_ADDR
  output logic                   REG_WR_STB,     // Write complete, pulse
  output logic [BYTE_W-1:0]      REG_WDATA,      // Written byte
  input  wire logic              FIFO_WR_EN,     // Receiver pushes a byte
  input  wire logic [BYTE_W-1:0] FIFO_WDATA,     // Byte pushed
  output logic                   FIFO_WR_READY,  // FIFO has room
  input  wire logic [LVL_W-1:0]  FIFO_THRESH,    // Threshold level, 1 to 32
  output logic                   FIFO_NOT_EMPTY, // Status, refreshed between reads
  output logic                   FIFO_TH_HIT,    // Status, level at or above threshold
  output logic                   FIFO_FULL       // Status, all bytes held
);
  // Frame states idle -> active -> wait -> idle; idle -> FIFO and register -> wait flip both bits
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_REG  = 2'b01,
    S_FIFO = 2'b11,
    S_WAIT = 2'b10
  } dev_state_e;
  dev_state_e              state_reg;          // Frame state
  logic                    scl_prev_reg;       // Serial clock, one cycle ago
  logic [BCNT_W-1:0]       bit_cnt_reg;        // Bits sampled this frame
  logic [BYTE_W-1:0]       in_shift_reg;       // Sampled bits, MSB first
  logic                    rw_read_reg;        // Direction bit of register frame
  logic [BYTE_W-1:0]       out_shift_reg;      // Bits to send, MSB at top
  logic                    oe_reg;             // Device drives data pin
  logic [BYTE_W-1:0]       mem [FIFO_DEPTH];   // FIFO storage
  logic [PTR_W-1:0]        rd_ptr_reg;         // Read pointer
  logic [PTR_W-1:0]        wr_ptr_reg;         // Write pointer
  logic [LVL_W-1:0]        level_reg;          // Bytes held
  logic [ADDR_W-1:0]       addr_reg;           // Captured address
  logic [BYTE_W-1:0]       wdata_reg;          // Captured write data
  logic                    wr_stb_reg;         // Write strobe
  logic                    rd_stb_reg;         // Read strobe
  logic                    nmty_reg;           // Status flags
  logic                    th_reg;
  logic                    full_reg;
  logic                    scl_rise;           // Rising serial clock edge
  logic                    scl_fall;           // Falling serial clock edge
  logic                    reg_sel;            // Register frame requested
  logic                    fifo_sel;           // FIFO read requested
  logic                    both_high;          // No select active
  logic                    pop;                // FIFO byte read out
  logic                    push;               // FIFO byte written
  logic [BYTE_W-1:0]       in_byte;            // Byte including bit now sampled
  // Edge detection on the sampled serial clock
  assign scl_rise  = LINK.scl & ~scl_prev_reg;
  assign scl_fall  = ~LINK.scl & scl_prev_reg;
  // A select only counts while the other one is high; both low is ignored
  assign reg_sel   = ~LINK.reg_select_n & LINK.fifo_select_n;  // see RQ1, RQ3
  assign fifo_sel  = ~LINK.fifo_select_n & LINK.reg_select_n;  // see RQ2, RQ3
  assign both_high = LINK.reg_select_n & LINK.fifo_select_n;
  assign in_byte   = {in_shift_reg[BYTE_W-2:0], LINK.sda};     // see RQ6
  // Byte counts as read once its last bit is sampled; empty FIFO never pops
  assign pop  = (state_reg == S_FIFO) && scl_rise && (bit_cnt_reg == FIFO_LAST_BIT)
                && (level_reg != LVL_RST);                       // see RQ10
  assign push = FIFO_WR_EN && (level_reg != LVL_FULL);
  // Clock history for edge detection
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      scl_prev_reg <= 1'b0;
    else
      scl_prev_reg <= LINK.scl;
  end
  // Frame state and bit counter
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      state_reg   <= S_IDLE;
      bit_cnt_reg <= '0;
    end
    else
    begin
      unique case (state_reg)
        S_IDLE:
        begin
          bit_cnt_reg <= '0;
          if (reg_sel)
            state_reg <= S_REG;                        // see RQ1, RQ14
          else if (fifo_sel)
            state_reg <= SLEEP ? S_WAIT : S_FIFO;      // see RQ2, RQ14
        end
        S_REG:
        begin
          if (!reg_sel)
            state_reg <= S_IDLE;                       // Frame cut short
          else if (scl_rise)
          begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;        // see RQ4
            if (bit_cnt_reg == REG_LAST_BIT)
              state_reg <= S_WAIT;                     // see RQ15
          end
        end
        S_FIFO:
        begin
          if (!fifo_sel)
            state_reg <= S_IDLE;                       // Aborted, pointer kept
          else if (scl_rise)
          begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            if (bit_cnt_reg == FIFO_LAST_BIT)
              state_reg <= S_WAIT;
          end
        end
        S_WAIT:
          if (both_high)                               // Extra clocks ignored till then
            state_reg <= S_IDLE;
      endcase
    end
  end
  // Incoming bits, sampled on rising edges, most significant first
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      in_shift_reg <= BYTE_RST;
      rw_read_reg  <= 1'b0;
    end
    else if (state_reg == S_REG && scl_rise)
    begin
      in_shift_reg <= in_byte;                         // see RQ4, RQ6
      if (bit_cnt_reg == '0)
        rw_read_reg <= LINK.sda;                       // High means read, see RQ7
    end
  end
  // Address capture and register strobes
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      addr_reg   <= '0;
      wdata_reg  <= BYTE_RST;
      wr_stb_reg <= 1'b0;
      rd_stb_reg <= 1'b0;
    end
    else
    begin
      wr_stb_reg <= 1'b0;
      rd_stb_reg <= 1'b0;
      if (state_reg == S_REG && scl_rise)
      begin
        if (bit_cnt_reg == ADDR_LAST_BIT)
        begin
          addr_reg   <= in_byte[ADDR_W-1:0];           // see RQ7
          rd_stb_reg <= rw_read_reg;
        end
        if (bit_cnt_reg == REG_LAST_BIT && !rw_read_reg)
        begin
          wdata_reg  <= in_byte;                       // see RQ15
          wr_stb_reg <= 1'b1;
        end
      end
    end
  end
  // Outgoing bits and data pin enable; shifts on falling edges, FIFO load and release follow the selects
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      out_shift_reg <= BYTE_RST;
      oe_reg        <= 1'b0;
    end
    else if (state_reg == S_IDLE)
    begin
      // FIFO byte goes out at once: MSB must be valid before first rise
      if (fifo_sel && !SLEEP)
      begin
        out_shift_reg <= mem[rd_ptr_reg];              // see RQ10
        oe_reg        <= 1'b1;                         // see RQ5
      end
      else
        oe_reg <= 1'b0;
    end
    else if ((state_reg == S_REG && !reg_sel) || (state_reg == S_FIFO && !fifo_sel)
             || (state_reg == S_WAIT && both_high))
      oe_reg <= 1'b0;                                  // see RQ5
    else if (scl_fall && state_reg == S_REG)
    begin
      if (bit_cnt_reg == FIFO_BITS && rw_read_reg)     // Read data: fall after address
      begin
        out_shift_reg <= REG_RD_DATA;                  // see RQ15
        oe_reg        <= 1'b1;                         // see RQ5
      end
      else
        out_shift_reg <= {out_shift_reg[BYTE_W-2:0], 1'b0};  // see RQ4, RQ6
    end
    else if (scl_fall && state_reg == S_FIFO)
      out_shift_reg <= {out_shift_reg[BYTE_W-2:0], 1'b0};    // see RQ4, RQ6
  end
  // FIFO storage, written by the receiver; not reset, to keep it cheap
  always_ff @(posedge CLK)
    if (push)
      mem[wr_ptr_reg] <= FIFO_WDATA;
  // Pointers and fill level; pointers wrap at 32 by their width
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      rd_ptr_reg <= PTR_RST;
      wr_ptr_reg <= PTR_RST;
      level_reg  <= LVL_RST;
    end
    else
    begin
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + 5'h01;              // see RQ10
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 5'h01;
      if (push && !pop)
        level_reg <= level_reg + 6'h01;
      else if (pop && !push)
        level_reg <= level_reg - 6'h01;
    end
  end
  // Flags follow the level only while FIFO select is high, never mid-read
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      nmty_reg <= 1'b0;
      th_reg   <= 1'b0;
      full_reg <= 1'b0;
    end
    else if (LINK.fifo_select_n)
    begin
      nmty_reg <= (level_reg != LVL_RST);              // see RQ13
      th_reg   <= (level_reg >= FIFO_THRESH);
      full_reg <= (level_reg == LVL_FULL);
    end
  end
  assign LINK.sda_dev_o  = out_shift_reg[BYTE_W-1];
  assign LINK.sda_dev_oe = oe_reg;
  assign REG_ADDR        = addr_reg;
  assign REG_RD_STB      = rd_stb_reg;
  assign REG_WR_STB      = wr_stb_reg;
  assign REG_WDATA       = wdata_reg;
  assign FIFO_WR_READY   = (level_reg != LVL_FULL);
  assign FIFO_NOT_EMPTY  = nmty_reg;
  assign FIFO_TH_HIT     = th_reg;
  assign FIFO_FULL       = full_reg;
endmodule : rf_spi_device

// file: core/rf_spi_host.sv
// Host end of the serial port: runs one register or FIFO frame per command.
// Assumes the device end follows the same link timing; SCL made by divider.
`timescale 1ns/1ps
module rf_spi_host
  import rf_spi_pkg::*;
(
  input  wire logic              CLK,        // System clock
  input  wire logic              ARST_N,     // Async reset, active low
  spi_link_if.host               LINK,       // Serial link
  input  wire logic              CMD_VALID,  // Command offered
  output logic                   CMD_READY,  // Command taken when both high
  input  wire logic              CMD_FIFO,   // 1: FIFO byte read, 0: register
  input  wire logic              CMD_READ,   // Register direction, 1 = read
  input  wire logic [ADDR_W-1:0] CMD_ADDR,   // Register address
  input  wire logic [BYTE_W-1:0] CMD_WDATA,  // Register write data
  output logic                   RSP_VALID,  // Read data ready, pulse
  output logic [BYTE_W-1:0]      RSP_DATA    // Read data
);

  // Host states, Gray coded along setup -> high <-> low and hold -> gap, not high -> hold
  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_SETUP = 3'b001,
    H_HIGH  = 3'b011,
    H_LOW   = 3'b010,
    H_HOLD  = 3'b110,
    H_GAP   = 3'b111
  } host_state_e;

  host_state_e         state_reg;      // Frame state
  logic [TMR_W-1:0]    timer_reg;      // Cycles left in phase
  logic [BCNT_W-1:0]   bit_cnt_reg;    // Falling edges issued
  logic [BCNT_W-1:0]   bits_reg;       // Frame length
  logic                fifo_reg;       // Frame is a FIFO read
  logic                read_reg;       // Frame returns data
  logic [15:0]         tx_shift_reg;   // Direction, address, data, MSB first
  logic [BYTE_W-1:0]   rx_shift_reg;   // Sampled bits
  logic                reg_sel_n_reg;  // Link and response outputs
  logic                fifo_sel_n_reg;
  logic                scl_reg;
  logic                oe_reg;
  logic                rsp_valid_reg;
  logic [BYTE_W-1:0]   rsp_data_reg;
  logic                tmr_done;       // Phase finished
  logic                last_bit;       // Falling edge ends frame

  assign tmr_done  = (timer_reg == '0);
  assign last_bit  = (bit_cnt_reg + 5'h01 == bits_reg);
  assign CMD_READY = (state_reg == H_IDLE);

  // Sequencer: selects, clock phases and hold / gap timing
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      state_reg      <= H_IDLE;
      timer_reg      <= '0;
      bit_cnt_reg    <= '0;
      bits_reg       <= REG_BITS;
      fifo_reg       <= 1'b0;
      read_reg       <= 1'b0;
      reg_sel_n_reg  <= 1'b1;
      fifo_sel_n_reg <= 1'b1;
      scl_reg        <= 1'b0;
    end
    else
    begin
      if (!tmr_done)
        timer_reg <= timer_reg - 10'h001;
      unique case (state_reg)
        H_IDLE:
        begin
          bit_cnt_reg <= '0;
          if (CMD_VALID)
          begin
            fifo_reg <= CMD_FIFO;
            read_reg <= CMD_FIFO | CMD_READ;
            bits_reg <= CMD_FIFO ? FIFO_BITS : REG_BITS;
            // Only one select ever goes low
            reg_sel_n_reg  <= CMD_FIFO;                   // see RQ1, RQ3
            fifo_sel_n_reg <= ~CMD_FIFO;                  // see RQ2, RQ3
            timer_reg <= CMD_FIFO ? T_FULL : T_HALF;      // see RQ8, RQ11
            state_reg <= H_SETUP;
          end
        end
        H_SETUP, H_LOW:
        begin
          if (tmr_done)
          begin
            scl_reg   <= 1'b1;                            // see RQ4
            timer_reg <= T_HALF;
            state_reg <= H_HIGH;
          end
        end
        H_HIGH:
        begin
          if (tmr_done)
          begin
            scl_reg     <= 1'b0;
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            if (last_bit)
            begin
              timer_reg <= fifo_reg ? T_HOLD : T_HALF;    // see RQ9, RQ12
              state_reg <= H_HOLD;
            end
            else
            begin
              timer_reg <= T_HALF;
              state_reg <= H_LOW;
            end
          end
        end
        H_HOLD:
        begin
          if (tmr_done)
          begin
            reg_sel_n_reg  <= 1'b1;
            fifo_sel_n_reg <= 1'b1;
            timer_reg <= fifo_reg ? T_GAP : T_HALF;       // see RQ13
            state_reg <= H_GAP;
          end
        end
        H_GAP:
        begin
          if (tmr_done)
            state_reg <= H_IDLE;
        end
        default:
          state_reg <= H_IDLE;                            // Unused codes
      endcase
    end
  end

  // Outgoing bits change on falling edges; pin released for read data
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      tx_shift_reg <= '0;
      oe_reg       <= 1'b0;
    end
    else if (state_reg == H_IDLE && CMD_VALID)
    begin
      tx_shift_reg <= {CMD_READ, CMD_ADDR, CMD_WDATA};    // see RQ6, RQ7, RQ15
      oe_reg       <= ~CMD_FIFO;                          // see RQ5
    end
    else if (state_reg == H_HIGH && tmr_done)
    begin
      tx_shift_reg <= {tx_shift_reg[14:0], 1'b0};         // see RQ4
      // Release after the address of a read, and at frame end
      if (last_bit || (read_reg && bit_cnt_reg == ADDR_LAST_BIT))
        oe_reg <= 1'b0;                                   // see RQ5
    end
  end

  // Sample on rising edges; answer once the select is back high
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      rx_shift_reg  <= BYTE_RST;
      rsp_valid_reg <= 1'b0;
      rsp_data_reg  <= BYTE_RST;
    end
    else
    begin
      rsp_valid_reg <= 1'b0;
      if ((state_reg == H_SETUP || state_reg == H_LOW) && tmr_done)
        rx_shift_reg <= {rx_shift_reg[BYTE_W-2:0], LINK.sda};  // see RQ4, RQ6
      if (state_reg == H_HOLD && tmr_done && read_reg)
      begin
        rsp_data_reg  <= rx_shift_reg;
        rsp_valid_reg <= 1'b1;
      end
    end
  end

  assign LINK.reg_select_n  = reg_sel_n_reg;
  assign LINK.fifo_select_n = fifo_sel_n_reg;
  assign LINK.scl           = scl_reg;
  assign LINK.sda_host_o    = tx_shift_reg[15];
  assign LINK.sda_host_oe   = oe_reg;
  assign RSP_VALID          = rsp_valid_reg;
  assign RSP_DATA           = rsp_data_reg;

endmodule : rf_spi_host

// file: bench/rf_spi_chk.sv
// Link checker: select, clock and data pin timing between the two ends.
// Assumes the link signals change only on the 200 MHz system clock.
`timescale 1ns/1ps
module rf_spi_chk (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic reg_select_n,
  input wire logic fifo_select_n,
  input wire logic scl,
  input wire logic sda_host_o,
  input wire logic sda_host_oe,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe
);
  logic       scl_reg;         // Serial clock one cycle late
  logic [9:0] since_fall_reg;  // Cycles since last clock fall, saturating
  // Saturate so a long idle stretch never wraps into a short hold
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      scl_reg        <= 1'b0;
      since_fall_reg <= 10'h3FF;
    end
    else
    begin
      scl_reg        <= scl;
      since_fall_reg <= (scl_reg && !scl) ? 10'h000 :
                        (since_fall_reg == 10'h3FF) ? 10'h3FF : since_fall_reg + 10'h001;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  property p_one_sel; !(!reg_select_n && !fifo_select_n); endproperty
  a_one_sel: assert property (p_one_sel) else $error("both selects low");
  property p_one_drv; !(sda_host_oe && sda_dev_oe); endproperty
  a_one_drv: assert property (p_one_drv) else $error("both ends drive data");
  property p_host_fall; $changed(sda_host_o) && sda_host_oe && $past(sda_host_oe) |-> !scl;
  endproperty
  a_host_fall: assert property (p_host_fall) else $error("host data moved high");
  property p_dev_fall; $changed(sda_dev_o) && sda_dev_oe && $past(sda_dev_oe) |-> !scl;
  endproperty
  a_dev_fall: assert property (p_dev_fall) else $error("device data moved high");
  property p_reg_setup; $fell(reg_select_n) |-> (!scl)[*8] ##1 !scl ##1 !scl; endproperty
  a_reg_setup: assert property (p_reg_setup) else $error("register setup short");
  property p_reg_hold; $fell(scl) && !reg_select_n |-> (!reg_select_n)[*8] ##1 !reg_select_n;
  endproperty
  a_reg_hold: assert property (p_reg_hold) else $error("register hold short");
  property p_fifo_setup; $fell(fifo_select_n) |-> (!scl)[*8] ##1 (!scl)[*8] ##1 (!scl)[*4];
  endproperty
  a_fifo_setup: assert property (p_fifo_setup) else $error("fifo setup short");
  // The counter lags one cycle, so 400 cycles of hold read as 399 at the rise
  property p_fifo_hold; $rose(fifo_select_n) |-> since_fall_reg >= 10'h18F; endproperty
  a_fifo_hold: assert property (p_fifo_hold) else $error("fifo hold short");
endmodule : rf_spi_chk

// file: bench/rf_receiver_spi_port_test.sv
// Bench joining host and device ends over the link; drives both user sides.
// Assumes the shared package and interface are compiled first.
`timescale 1ns/1ps
module rf_receiver_spi_port_test;
  import rf_spi_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, cmd_valid = 1'b0, cmd_fifo = 1'b0, cmd_read = 1'b0;
  logic sleep = 1'b0, fifo_wr_en = 1'b0, cmd_ready, rsp_valid, rd_stb, wr_stb;
  logic wr_ready, not_empty, th_hit, full;
  logic [6:0] cmd_addr = 7'h00, reg_addr;
  logic [7:0] cmd_wdata = 8'h00, fifo_wdata = 8'h00, rd_data = 8'hA5, rsp_data, wdata, rsp_q;
  logic [5:0] thresh = 6'h02; // Threshold two, reached by the second push
  logic [15:0] wire_bits;     // Bits seen on the pin at each clock rise
  int num_errors = 0, n_tests = 0, wr_cnt = 0, rd_cnt = 0;
  always #2.5 clk = ~clk;
  spi_link_if lnk();
  rf_spi_host rf_spi_host_i (.CLK(clk), .ARST_N(arst_n), .LINK(lnk), .CMD_VALID(cmd_valid),
    .CMD_READY(cmd_ready), .CMD_FIFO(cmd_fifo), .CMD_READ(cmd_read), .CMD_ADDR(cmd_addr),
    .CMD_WDATA(cmd_wdata), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data));
  rf_spi_device rf_spi_device_i (.CLK(clk), .ARST_N(arst_n), .LINK(lnk), .SLEEP(sleep),
    .REG_ADDR(reg_addr), .REG_RD_STB(rd_stb), .REG_RD_DATA(rd_data), .REG_WR_STB(wr_stb),
    .REG_WDATA(wdata), .FIFO_WR_EN(fifo_wr_en), .FIFO_WDATA(fifo_wdata),
    .FIFO_WR_READY(wr_ready), .FIFO_THRESH(thresh), .FIFO_NOT_EMPTY(not_empty),
    .FIFO_TH_HIT(th_hit), .FIFO_FULL(full));
  rf_spi_chk rf_spi_chk_i (.CLK(clk), .ARST_N(arst_n), .reg_select_n(lnk.reg_select_n),
    .fifo_select_n(lnk.fifo_select_n), .scl(lnk.scl), .sda_host_o(lnk.sda_host_o),
    .sda_host_oe(lnk.sda_host_oe), .sda_dev_o(lnk.sda_dev_o), .sda_dev_oe(lnk.sda_dev_oe));
  // Receiver samples the pin on the rise, so the bench does too
  always @(posedge lnk.scl) wire_bits <= {wire_bits[14:0], lnk.sda};
  // Answers and write strobes are single-cycle pulses, so latch them
  always @(posedge clk) if (rsp_valid) rsp_q <= rsp_data;
  always @(posedge clk) if (wr_stb) wr_cnt <= wr_cnt + 1;
  always @(posedge clk) if (rd_stb) rd_cnt <= rd_cnt + 1;
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask : check
  // One command, then a bounded wait until the host is idle again
  task automatic run_cmd(input logic f, input logic r, input logic [6:0] a, input logic [7:0] d);
    int i;
    {cmd_fifo, cmd_read, cmd_addr, cmd_wdata, cmd_valid} = {f, r, a, d, 1'b1};
    @(posedge clk);
    #1 cmd_valid = 1'b0;
    for (i = 0; i < 2000 && cmd_ready !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    if (i == 2000)
    begin
      num_errors++;
      print_verdict();
    end
  endtask : run_cmd
  task automatic reg_write_test();
    run_cmd(1'b0, 1'b0, 7'h5A, 8'hC3);
    check(wire_bits, {1'b0, 7'h5A, 8'hC3});
    check({8'h00, wdata}, 16'h00C3);
    check({9'h000, reg_addr}, 16'h005A);
  endtask : reg_write_test
  task automatic reg_read_test();
    run_cmd(1'b0, 1'b1, 7'h33, 8'h00);
    check(wire_bits, {1'b1, 7'h33, 8'hA5});
    check({8'h00, rsp_q}, 16'h00A5);
    check({9'h000, reg_addr}, 16'h0033);
  endtask : reg_read_test
  // One push per cycle; the enable stays high, the caller lowers it afterwards
  task automatic push_byte(input logic [7:0] d);
    {fifo_wr_en, fifo_wdata} = {1'b1, d};
    @(posedge clk);
    #1;
  endtask : push_byte
  // Back-to-back byte reads with the host's own gap between them
  task automatic fifo_test();
    logic [7:0] b [3] = '{8'h81, 8'h3C, 8'hE7};
    foreach (b[k])
      push_byte(b[k]);
    fifo_wr_en = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check({15'h0000, th_hit}, 16'h0001);
    for (int k = 0; k < 2; k++)
    begin
      run_cmd(1'b1, 1'b0, 7'h00, 8'h00);
      check({8'h00, rsp_q}, {8'h00, b[k]});
      check(wire_bits[7:0], b[k]);
    end
    check({14'h0000, th_hit, not_empty}, 16'h0001);
  endtask : fifo_test
  // Sleep still serves registers but leaves the pin released for FIFO reads
  task automatic sleep_test();
    sleep = 1'b1;
    run_cmd(1'b0, 1'b0, 7'h11, 8'h0F);
    check({8'h00, wdata}, 16'h000F);
    run_cmd(1'b1, 1'b0, 7'h00, 8'h00);
    check({8'h00, rsp_q}, 16'h00FF);
    sleep = 1'b0;
    run_cmd(1'b1, 1'b0, 7'h00, 8'h00);
    check({8'h00, rsp_q}, 16'h00E7);
    check(16'(wr_cnt), 16'h0002);
    check(16'(rd_cnt), 16'h0001);
  endtask : sleep_test
  // Thirty-three pushes into an empty FIFO: the last finds no room and is dropped
  task automatic full_test();
    for (int k = 0; k < 33; k++)
      push_byte(8'(8'h40 + k));
    fifo_wr_en = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check({14'h0000, full, wr_ready}, 16'h0002);
    run_cmd(1'b1, 1'b0, 7'h00, 8'h00);
    check({8'h00, rsp_q}, 16'h0040);
    check({14'h0000, full, wr_ready}, 16'h0001);
  endtask : full_test
  initial
  begin
    repeat (6) @(posedge clk);
    #1 arst_n = 1'b1;
    reg_write_test();
    reg_read_test();
    fifo_test();
    sleep_test();
    full_test();
    print_verdict();
  end
endmodule : rf_receiver_spi_port_test
